// ==== src/pbo_top.sv ====
// Purpose: Output control and configuration core of an 8-port expander
// Assumes: Register port comes from a serial protocol engine
// Notes: Open-drain pins; oe high means the pin is pulled low
`include "pbo_params.svh"

module pbo_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    input wire logic alert_or_aux_out_pin_in,
    output logic alert_or_aux_out_pin_out,
    output logic alert_or_aux_out_pin_oe,
    output logic [31:0] port_intensity,
    output logic [3:0] ninth_output_intensity,
    output logic [3:0] master_intensity
);

    // Open-drain pull decision shared by ports and the ninth output
    function automatic logic od_pull(input logic level, input logic is_out);
        od_pull = is_out & ~level;
    endfunction : od_pull

    logic rst_meta_q;
    logic rst_n_q;
    pbo_pkg::pbo_byte_t phase0_q;
    pbo_pkg::pbo_byte_t phase1_q;
    pbo_pkg::pbo_byte_t dir_q;
    pbo_pkg::pbo_byte_t master_q;
    pbo_pkg::pbo_byte_t config_q;
    pbo_pkg::pbo_byte_t intens_q [4];
    pbo_pkg::pbo_byte_t reg_rdata_q;
    logic [7:0] port_oe_q;
    logic [7:0] port_out_q;
    logic aux_oe_q;
    logic aux_out_q;
    logic [31:0] port_int_q;
    logic [3:0] ninth_int_q;
    logic [3:0] master_int_q;
    logic blink_en;
    logic use_phase1;
    pbo_pkg::pbo_byte_t pattern;
    logic aux_level;
    pbo_pkg::pbo_pin_mode_e pin_mode;
    pbo_pkg::pbo_byte_t config_rd;
    logic [1:0] int_idx;
    logic wr_int;
    logic rd_int;

    pbo_if det_bus ();

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Intensity window decode
    assign int_idx = reg_addr[1:0];
    assign wr_int = reg_wr_en && (reg_addr >= `PBO_ADDR_INT_FIRST)
                    && (reg_addr <= `PBO_ADDR_INT_LAST);
    assign rd_int = (reg_addr >= `PBO_ADDR_INT_FIRST)
                    && (reg_addr <= `PBO_ADDR_INT_LAST);

    // Phase pattern registers
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase0_q <= `PBO_RST_PHASE0;
            phase1_q <= `PBO_RST_PHASE1;
        end else if (reg_wr_en) begin
            if (reg_addr == `PBO_ADDR_PHASE0) begin
                phase0_q <= reg_wdata;
            end
            if (reg_addr == `PBO_ADDR_PHASE1) begin
                phase1_q <= reg_wdata;
            end
        end
    end

    // Port direction register
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dir_q <= `PBO_RST_DIR;
        end else if (reg_wr_en && reg_addr == `PBO_ADDR_DIR) begin
            dir_q <= reg_wdata;
        end
    end

    // Master and ninth output intensity register
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            master_q <= `PBO_RST_MASTER;
        end else if (reg_wr_en && reg_addr == `PBO_ADDR_MASTER) begin
            master_q <= reg_wdata;
        end
    end

    // Configuration register; level bits kept in either pin role
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            config_q <= `PBO_RST_CONFIG;
        end else if (reg_wr_en && reg_addr == `PBO_ADDR_CONFIG) begin
            config_q <= reg_wdata & `PBO_CFG_WR_MASK;
        end
    end

    // Individual intensity registers, two ports per byte
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < 4; i++) begin
                intens_q[i] <= `PBO_RST_INTENS;
            end
        end else if (wr_int) begin
            intens_q[int_idx] <= reg_wdata;
        end
    end

    // Change detector takes a fresh sample on input read or config write
    assign det_bus.port_in = port_in;
    assign det_bus.dir = dir_q;
    assign det_bus.sample_req = (reg_rd_en && reg_addr == `PBO_ADDR_INPUT)
        || (reg_wr_en && reg_addr == `PBO_ADDR_CONFIG);

    pbo_change_det u_change_det (
        .sys_clk(sys_clk),
        .rst_n(rst_n_q),
        .bus(det_bus)
    );

    // Config read-back: change flag on top, bit 6 zero
    always_comb begin
        config_rd = config_q & `PBO_CFG_WR_MASK;
        config_rd[`PBO_CFG_CHANGE] = det_bus.changed;
        config_rd[`PBO_CFG_RSVD] = 1'b0;
    end

    // Register read port, answer one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            if (rd_int) begin
                reg_rdata_q <= intens_q[int_idx];
            end else begin
                case (reg_addr)
                    `PBO_ADDR_INPUT: reg_rdata_q <= port_in;
                    `PBO_ADDR_PHASE0: reg_rdata_q <= phase0_q;
                    `PBO_ADDR_DIR: reg_rdata_q <= dir_q;
                    `PBO_ADDR_PHASE1: reg_rdata_q <= phase1_q;
                    `PBO_ADDR_MASTER: reg_rdata_q <= master_q;
                    `PBO_ADDR_CONFIG: reg_rdata_q <= config_rd;
                    default: reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Blink phase and pattern selection
    assign blink_en = config_q[`PBO_CFG_BLINK_EN];
    assign use_phase1 = blink_en & config_q[`PBO_CFG_FLIP];
    assign pattern = use_phase1 ? phase1_q : phase0_q;
    assign aux_level = use_phase1 ? config_q[`PBO_CFG_LVL1]
                                  : config_q[`PBO_CFG_LVL0];
    assign pin_mode = config_q[`PBO_CFG_ALERT_EN] ? pbo_pkg::PIN_ALERT
                                                  : pbo_pkg::PIN_AUX;

    // Port pins: pull low only for outputs with a zero pattern bit
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            port_oe_q <= 8'h00;
            port_out_q <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                port_oe_q[i] <= od_pull(pattern[i], ~dir_q[i]);
            end
            port_out_q <= 8'h00;
        end
    end

    // Combined pin: alert pulls low on change, else ninth output level
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aux_oe_q <= 1'b0;
            aux_out_q <= 1'b0;
        end else begin
            aux_out_q <= 1'b0;
            case (pin_mode)
                pbo_pkg::PIN_ALERT: aux_oe_q <= det_bus.changed;
                pbo_pkg::PIN_AUX: begin
                    aux_oe_q <= od_pull(aux_level, 1'b1);
                end
                default: aux_oe_q <= 1'b0;
            endcase
        end
    end

    // Intensity outputs toward the PWM generator
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            port_int_q <= 32'hFFFFFFFF;
            ninth_int_q <= 4'hF;
            master_int_q <= 4'hF;
        end else begin
            master_int_q <= master_q[3:0];
            if (config_q[`PBO_CFG_GLOBAL]) begin
                port_int_q <= {8{master_q[3:0]}};
                ninth_int_q <= master_q[3:0];
            end else begin
                port_int_q <= {intens_q[3], intens_q[2],
                               intens_q[1], intens_q[0]};
                ninth_int_q <= master_q[7:4];
            end
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign port_out = port_out_q;
    assign port_oe = port_oe_q;
    assign alert_or_aux_out_pin_out = aux_out_q;
    assign alert_or_aux_out_pin_oe = aux_oe_q;
    assign port_intensity = port_int_q;
    assign ninth_output_intensity = ninth_int_q;
    assign master_intensity = master_int_q;

    // Pin read-back is not needed by this core
    logic unused_pin;
    assign unused_pin = alert_or_aux_out_pin_in;

endmodule : pbo_top

// ==== include/pbo_params.svh ====
// Purpose: Offsets, field positions, reset values of the port expander core
// Assumes: Byte-wide register port from the serial protocol engine
// Notes: Included by pbo_top only; the package and the change detector do not include it
`ifndef PBO_PARAMS_SVH
`define PBO_PARAMS_SVH

// Register offsets
`define PBO_ADDR_INPUT 8'h00
`define PBO_ADDR_PHASE0 8'h01
`define PBO_ADDR_DIR 8'h03
`define PBO_ADDR_PHASE1 8'h09
`define PBO_ADDR_MASTER 8'h0E
`define PBO_ADDR_CONFIG 8'h0F
`define PBO_ADDR_INT_FIRST 8'h10
`define PBO_ADDR_INT_LAST 8'h13

// Configuration field positions
`define PBO_CFG_BLINK_EN 0
`define PBO_CFG_FLIP 1
`define PBO_CFG_GLOBAL 2
`define PBO_CFG_ALERT_EN 3
`define PBO_CFG_LVL0 4
`define PBO_CFG_LVL1 5
`define PBO_CFG_RSVD 6
`define PBO_CFG_CHANGE 7
`define PBO_CFG_WR_MASK 8'h3F

// Reset values
`define PBO_RST_PHASE0 8'hFF
`define PBO_RST_DIR 8'hFF
`define PBO_RST_PHASE1 8'hFF
`define PBO_RST_MASTER 8'h0F
`define PBO_RST_CONFIG 8'h0C
`define PBO_RST_INTENS 8'hFF

`endif

// ==== include/pbo_pkg.sv ====
// Purpose: Shared types of the port expander output and config core
// Assumes: pbo_params.svh holds the numbers
// Notes: Never imported; used as pbo_pkg::name
package pbo_pkg;

    typedef logic [7:0] pbo_byte_t;

    // Role of the combined alert/aux pin, one-hot
    typedef enum logic [1:0] {
        PIN_ALERT = 2'b01,
        PIN_AUX = 2'b10
    } pbo_pin_mode_e;

endpackage : pbo_pkg

// ==== include/pbo_if.sv ====
// Purpose: Carrier between the control core and the change detector
// Assumes: Single clock domain
// Notes: ctl drives direction and sample requests, det reports a change
interface pbo_if;
    logic [7:0] port_in;
    logic [7:0] dir;
    logic sample_req;
    logic changed;
    logic [7:0] sample;

    modport ctl (output port_in, output dir, output sample_req,
                 input changed, input sample);
    modport det (input port_in, input dir, input sample_req,
                 output changed, output sample);
endinterface : pbo_if

// ==== src/pbo_change_det.sv ====
// Purpose: Input transition detector for the eight ports
// Assumes: Port inputs already synchronous to sys_clk
// Notes: Sample taken first cycle after reset release and on request
module pbo_change_det (
    input wire logic sys_clk,
    input wire logic rst_n,
    pbo_if.det bus
);

    logic init_done_q;
    logic [7:0] sample_q;
    logic changed_q;

    // Mark the first cycle after reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    // Capture the reference sample at start-up and on request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_q <= 8'hFF;
        end else if (!init_done_q || bus.sample_req) begin
            sample_q <= bus.port_in;
        end
    end

    // Any input port differing from its sample flags a change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            changed_q <= 1'b0;
        end else if (!init_done_q || bus.sample_req) begin
            changed_q <= 1'b0;
        end else begin
            changed_q <= |((bus.port_in ^ sample_q) & bus.dir);
        end
    end

    assign bus.changed = changed_q;
    assign bus.sample = sample_q;

endmodule : pbo_change_det

// ==== dv/pbo_top_assertions.sv ====
// Purpose: Port-level checks of the expander core
// Assumes: Read and write strobes never overlap
// Notes: Keeps a shadow of the writable registers
module pbo_top_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic alert_or_aux_out_pin_in,
    input wire logic alert_or_aux_out_pin_out,
    input wire logic alert_or_aux_out_pin_oe,
    input wire logic [31:0] port_intensity,
    input wire logic [3:0] ninth_output_intensity,
    input wire logic [3:0] master_intensity
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] ph0_q, ph1_q, dir_q, mst_q, cfg_q, exp_oe, rv, rm, nin;
    logic [31:0] ints_q, gl;
    logic glb, aux, pin_lo, rd_ok;

    // Shadow registers, updated at the strobe edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph0_q <= 8'hFF;
            ph1_q <= 8'hFF;
            dir_q <= 8'hFF;
            mst_q <= 8'h0F;
            cfg_q <= 8'h0C;
            ints_q <= 32'hFFFFFFFF;
        end else if (reg_wr_en) begin
            case (reg_addr)
                8'h01: ph0_q <= reg_wdata;
                8'h03: dir_q <= reg_wdata;
                8'h09: ph1_q <= reg_wdata;
                8'h0E: mst_q <= reg_wdata;
                8'h0F: cfg_q <= reg_wdata & 8'h3F;
                8'h10, 8'h11, 8'h12, 8'h13: begin
                    ints_q[8*reg_addr[1:0] +: 8] <= reg_wdata;
                end
                default: ;
            endcase
        end
    end

    // Expected pin drive, intensities and read value
    always_comb begin
        exp_oe = ~((cfg_q[0] & cfg_q[1]) ? ph1_q : ph0_q) & ~dir_q;
        pin_lo = ~((cfg_q[0] & cfg_q[1]) ? cfg_q[5] : cfg_q[4]);
        glb = cfg_q[2];
        aux = ~cfg_q[3];
        gl = {8{mst_q[3:0]}};
        nin = {2{mst_q[7:4]}};
        rd_ok = reg_rd_en & (reg_addr != 8'h00);
        rm = (reg_addr == 8'h0F) ? 8'h7F : 8'hFF;
        case (reg_addr)
            8'h01: rv = ph0_q;
            8'h03: rv = dir_q;
            8'h09: rv = ph1_q;
            8'h0E: rv = mst_q;
            8'h0F: rv = cfg_q;
            8'h10, 8'h11, 8'h12, 8'h13: rv = ints_q[8*reg_addr[1:0] +: 8];
            default: rv = 8'h00;
        endcase
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_port_drive: assert property (
        port_oe == $past(exp_oe)) else $error("port drive wrong");
    a_aux_level: assert property ($past(aux) |->
        alert_or_aux_out_pin_oe == $past(pin_lo))
        else $error("aux level wrong");
    a_glob_port: assert property ($past(glb) |->
        port_intensity == $past(gl)) else $error("global port level wrong");
    a_glob_ninth: assert property ($past(glb) |->
        {8{ninth_output_intensity}} == $past(gl))
        else $error("global ninth wrong");
    a_indiv_int: assert property (!$past(glb) |->
        port_intensity == $past(ints_q)
        && {2{ninth_output_intensity}} == $past(nin))
        else $error("individual intensity wrong");
    a_master_int: assert property (
        {8{master_intensity}} == $past(gl))
        else $error("master intensity wrong");
    a_read_back: assert property ($past(rd_ok) |->
        (reg_rdata & $past(rm)) == $past(rv)) else $error("read back wrong");
    a_open_drain: assert property (port_out == 8'h00 ##1
        !alert_or_aux_out_pin_out) else $error("driven high");

    c_blink_p1: cover property (cfg_q[1:0] == 2'b11);
    c_alert_low: cover property (!aux && alert_or_aux_out_pin_oe);
    c_cfg_read: cover property (reg_rd_en && reg_addr == 8'h0F);
endmodule : pbo_top_assertions

bind pbo_top pbo_top_assertions i_pbo_top_assertions (.*);

// ==== dv/pbo_host.sv ====
// Purpose: Host controller model on the register port
// Assumes: One strobe per byte, never read and write together
// Notes: Signals change only after a rising edge
module pbo_host (
    input wire logic sys_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : pbo_host

// ==== dv/tb_pbo_top.sv ====
// Purpose: Self-checking bench of the expander core
// Assumes: Pull-ups on every pin
// Notes: Host model drives the register port
module tb_pbo_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, arst_n, reg_wr_en, reg_rd_en;
    logic alert_or_aux_out_pin_in, alert_or_aux_out_pin_out;
    logic alert_or_aux_out_pin_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_in, port_out;
    logic [7:0] port_oe, ext_q;
    logic [31:0] port_intensity;
    logic [3:0] ninth_output_intensity, master_intensity;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    // Open-drain wires with pull-ups
    assign port_in = ext_q & ~port_oe;
    assign alert_or_aux_out_pin_in = ~alert_or_aux_out_pin_oe;

    pbo_top i_pbo_top (.*);
    pbo_host i_pbo_host (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_pbo_host.rd(a, d);
        chk("reg_rdata", d, e);
    endtask : rdchk

    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic t_reset;
        rdchk(8'h0F, 8'h0C);
        rdchk(8'h03, 8'hFF);
        rdchk(8'h09, 8'hFF);
        rdchk(8'h05, 8'h00);
        chk("port_oe", port_oe, 8'h00);
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b0);
        chk("port_out", port_out, 8'h00);
        chk("pin_out", alert_or_aux_out_pin_out, 1'b0);
    endtask : t_reset

    // Every blink enable and flip combination, each with level 0 set and with level 1 set
    task automatic t_blink;
        logic [7:0] cfg;
        logic sel;
        i_pbo_host.wr(8'h03, 8'h0F);
        i_pbo_host.wr(8'h01, 8'hA5);
        i_pbo_host.wr(8'h09, 8'h3C);
        for (int i = 0; i < 8; i++) begin
            cfg = (i[2] ? 8'h10 : 8'h20) | 8'(i[1:0]);
            sel = i[0] & i[1];
            i_pbo_host.wr(8'h0F, cfg);
            settle();
            chk("port_oe", port_oe, sel ? 8'hC0 : 8'h50);
            chk("pin_oe", alert_or_aux_out_pin_oe,
                sel ? i[2] : !i[2]);
            rdchk(8'h0F, cfg);
        end
        rdchk(8'h01, 8'hA5);
    endtask : t_blink

    task automatic t_intens;
        i_pbo_host.wr(8'h0E, 8'h9A);
        i_pbo_host.wr(8'h0F, 8'h04);
        settle();
        chk("port_int", port_intensity, 32'hAAAAAAAA);
        chk("ninth_int", ninth_output_intensity, 4'hA);
        chk("master_int", master_intensity, 4'hA);
        for (int i = 0; i < 4; i++) begin
            i_pbo_host.wr(8'h10 + 8'(i), 8'h21 + 8'(i * 17));
        end
        i_pbo_host.wr(8'h0F, 8'h00);
        settle();
        chk("port_int", port_intensity, 32'h54433221);
        chk("ninth_int", ninth_output_intensity, 4'h9);
    endtask : t_intens

    task automatic t_alert;
        i_pbo_host.wr(8'h03, 8'hFF);
        i_pbo_host.wr(8'h0F, 8'hC8);
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b0);
        rdchk(8'h0F, 8'h08);
        @(posedge sys_clk);
        ext_q <= 8'hFB;
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b1);
        rdchk(8'h0F, 8'h88);
        rdchk(8'h00, 8'hFB);
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b0);
        @(posedge sys_clk);
        ext_q <= 8'hFF;
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b1);
        i_pbo_host.wr(8'h0F, 8'h18);
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b0);
        @(posedge sys_clk);
        ext_q <= 8'hFB;
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b1);
        @(posedge sys_clk);
        ext_q <= 8'hFF;
        settle();
        chk("pin_oe", alert_or_aux_out_pin_oe, 1'b0);
        rdchk(8'h0F, 8'h18);
    endtask : t_alert

    task automatic stop_test;
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        arst_n = 1'b0;
        ext_q = 8'hFF;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_blink();
        t_intens();
        t_alert();
        stop_test();
    end
endmodule : tb_pbo_top
